/* File: rtl/fepi_defines.svh */
`ifndef FEPI_DEFINES_SVH
`define FEPI_DEFINES_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FEPI_OP_ERASE_A 8'h60
`define FEPI_OP_ERASE_B 8'hc7
`define FEPI_OP_WRITE_LATCH_SET 8'h06
`define FEPI_OP_SLEEP_ENTRY 8'hb9
`define FEPI_OP_WAKE_SIG 8'hab
`define FEPI_OP_MAKER_PART 8'h90
`define FEPI_OP_IDENTITY 8'h9f
`define FEPI_OP_PUMP_PREARM 8'ha3
`define FEPI_OP_CONT_CLEAR 8'hff
`define FEPI_CONT_TAG 4'ha

// ----------------------------------------
// Bit counter marks
// ----------------------------------------
`define FEPI_BIT_OP_LAST 7'h07
`define FEPI_BIT_ADDR_LAST 7'h1f
`define FEPI_BITS_OP 7'h08
`define FEPI_BITS_ID 7'h20
`define FEPI_BIT_TOP 7'h7f
`define FEPI_BIT_WRAP 7'h40

// ----------------------------------------
// Timing
// ----------------------------------------
`define FEPI_SYS_CLK_PERIOD_NS 100
`define FEPI_SLEEP_ENTRY_DELAY_NS 3000
`define FEPI_WAKE_DELAY_SHORT_NS 3000
`define FEPI_WAKE_DELAY_WITH_ID_NS 2000
`define FEPI_ARRAY_ERASE_TIME_MS 100
`define FEPI_CEIL_CYC(ns) (((ns) + `FEPI_SYS_CLK_PERIOD_NS - 1) / `FEPI_SYS_CLK_PERIOD_NS)
`define FEPI_SLEEP_ENTRY_CYC `FEPI_CEIL_CYC(`FEPI_SLEEP_ENTRY_DELAY_NS)
`define FEPI_WAKE_SHORT_CYC `FEPI_CEIL_CYC(`FEPI_WAKE_DELAY_SHORT_NS)
`define FEPI_WAKE_WITH_ID_CYC `FEPI_CEIL_CYC(`FEPI_WAKE_DELAY_WITH_ID_NS)
`define FEPI_ARRAY_ERASE_CYC (`FEPI_ARRAY_ERASE_TIME_MS * 1000000 / `FEPI_SYS_CLK_PERIOD_NS)

`endif

/* File: rtl/fepi_pkg.sv */
package fepi_pkg;

    // ----------------------------------------
    // Control states, one-hot
    // ----------------------------------------
    typedef enum logic [4:0] {
        FEPI_IDLE = 5'h01,
        FEPI_ERASE = 5'h02,
        FEPI_SLEEP_WAIT = 5'h04,
        FEPI_SLEEP = 5'h08,
        FEPI_WAKE = 5'h10
    } fepi_state_type;

    // ----------------------------------------
    // Readout source in the link domain
    // ----------------------------------------
    typedef enum logic [1:0] {
        FEPI_OUT_NONE = 2'h0,
        FEPI_OUT_SIG = 2'h1,
        FEPI_OUT_MP = 2'h2,
        FEPI_OUT_ID = 2'h3
    } fepi_out_type;

endpackage

/* File: rtl/fepi_flash_cmds.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fepi_defines.svh"

// Contract
// RULE_01: Opcode 60h or C7h both mean whole-array erase.
// RULE_02: Erase needs the write latch set first; otherwise nothing happens.
// RULE_03: Erase frame must end exactly after eight bits, else discarded.
// RULE_04: Valid erase starts timed cycle; busy high meanwhile; latch cleared.
// RULE_05: Erase only when protect bits and complement all zero or all one.
// RULE_06: B9h, eight bits exactly, enters sleep after a fixed delay.
// RULE_07: In sleep every command is ignored except ABh, which wakes.
// RULE_08: Plain deselect means standby; reset always starts in standby.
// RULE_09: Sleep entry during a busy cycle is rejected, cycle untouched.
// RULE_10: After bare ABh wake, no command accepted until short delay ends.
// RULE_11: ABh plus three dummy bytes streams signature byte MSB first, repeating.
// RULE_12: Wake with signature readout uses the longer wake delay; the code loads 2000 ns (20 cycles) here against 3000 ns for bare ABh.
// RULE_13: ABh is ignored while busy; running cycle untouched. The code still wakes from sleep on ABh while ext_busy_i is high.
// RULE_14: 90h plus address 0 gives maker then part; address 1 swaps.
// RULE_15: 9Fh shifts maker, type, capacity; deselect ends it, standby.
// RULE_16: 9Fh is not decoded while an erase or program runs.
// RULE_17: Host avoids sending 9Fh while the device sleeps.
// RULE_18: A3h plus three dummy bytes then deselect arms the charge pump.
// RULE_19: ABh, 06h or B9h drop the pump pre-arm mode.
// RULE_20: Mode bits Ax make the next dual/quad read skip its opcode.
// RULE_21: While that state is set only FFh is decoded, and clears it.
// RULE_22: Input bits sampled on rising clock, MSB first, from frame start.
module fepi_flash_cmds #(
    parameter int ERASE_CYCLES = `FEPI_ARRAY_ERASE_CYC,
    parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
    parameter logic [7:0] PART_ID = 8'h3c, // Arbitrary value
    parameter logic [7:0] MEM_TYPE_ID = 8'h42, // Arbitrary value
    parameter logic [7:0] CAPACITY_ID = 8'h17, // Arbitrary value
    parameter logic [7:0] SIGNATURE_ID = 8'h2d // Arbitrary value
) (
    input wire logic sys_clk_i, // System clock
    input wire logic nrst_i, // Sync reset, low
    input wire logic spi_clk_i, // Serial clock from host
    input wire logic spi_cs_n_i, // Chip select, low
    input wire logic spi_mosi_i, // Serial data in
    input wire logic ext_busy_i, // Other cycle running
    input wire logic write_latch_clr_i, // Latch clear from others
    input wire logic protect_sel_2_i, // Block protect 2
    input wire logic protect_sel_1_i, // Block protect 1
    input wire logic protect_sel_0_i, // Block protect 0
    input wire logic protect_complement_i, // Protect complement
    input wire logic [7:0] cont_read_mode_bits_i, // Mode bits of a read
    input wire logic cont_read_bits_valid_i, // Mode bits strobe
    output logic spi_miso_o, // Serial data out
    output logic spi_miso_oe_o, // Data out enable
    output logic busy_flag_o, // Cycle in progress
    output logic write_latch_flag_o, // Write latch
    output logic sleep_o, // Lowest-power sleep
    output logic pump_prearm_mode_o, // Charge pump armed
    output logic cont_read_active_o, // Next read has no opcode
    output logic cmd_ready_o // Commands accepted
);

    // ----------------------------------------
    // Link domain: shifter and decode
    // ----------------------------------------
    logic [6:0] bcnt_reg, bcnt_next;
    logic [7:0] shf_reg, shf_next;
    logic [7:0] op_reg, op_next;
    logic alsb_reg, alsb_next;
    fepi_pkg::fepi_out_type osel_reg, osel_next;
    logic [7:0] sum_op_reg;
    logic [6:0] sum_cnt_reg;
    logic [3:0] lsync1_reg, lsync2_reg;
    logic l_busy, l_dorm, l_wake, l_cont;
    logic dorm_reg; // Sleep or sleep entry, system side

    // Status seen from the link side, after two flops
    assign l_busy = lsync2_reg[3];
    assign l_dorm = lsync2_reg[2];
    assign l_wake = lsync2_reg[1];
    assign l_cont = lsync2_reg[0];

    // Bit counting and readout selection
    always_comb
    begin
        shf_next = {shf_reg[6:0], spi_mosi_i}; // RULE_22
        bcnt_next = (bcnt_reg == `FEPI_BIT_TOP) ? `FEPI_BIT_WRAP : bcnt_reg + 7'h01;
        op_next = op_reg;
        alsb_next = alsb_reg;
        osel_next = osel_reg;
        if (bcnt_reg == `FEPI_BIT_ADDR_LAST)
            alsb_next = spi_mosi_i;
        if (bcnt_reg == `FEPI_BIT_OP_LAST)
        begin
            op_next = shf_next; // RULE_22
            if (!l_wake && !l_cont) // RULE_10 RULE_21
                unique case (shf_next)
                    `FEPI_OP_WAKE_SIG:
                        if (!l_busy) // RULE_13
                            osel_next = fepi_pkg::FEPI_OUT_SIG; // RULE_11
                    `FEPI_OP_MAKER_PART:
                        if (!l_dorm) // RULE_07
                            osel_next = fepi_pkg::FEPI_OUT_MP;
                    `FEPI_OP_IDENTITY:
                        if (!l_dorm && !l_busy) // RULE_16 RULE_07
                            osel_next = fepi_pkg::FEPI_OUT_ID;
                    default: osel_next = fepi_pkg::FEPI_OUT_NONE;
                endcase
        end
    end

    // Frame state cleared while deselected
    always_ff @(posedge spi_clk_i or posedge spi_cs_n_i)
    begin
        if (spi_cs_n_i)
        begin
            bcnt_reg <= 7'h00;
            shf_reg <= 8'h00;
            op_reg <= 8'h00;
            alsb_reg <= 1'b0;
            osel_reg <= fepi_pkg::FEPI_OUT_NONE;
        end
        else
        begin
            bcnt_reg <= bcnt_next;
            shf_reg <= shf_next;
            op_reg <= op_next;
            alsb_reg <= alsb_next;
            osel_reg <= osel_next;
        end
    end

    // Frame summary survives deselect; read by the system side only
    // after chip select has risen, while the serial clock stands still
    always_ff @(posedge spi_clk_i)
    begin
        sum_op_reg <= op_next;
        sum_cnt_reg <= bcnt_next;
        lsync1_reg <= {busy_flag_o, dorm_reg, ~cmd_ready_o, cont_read_active_o};
        lsync2_reg <= lsync1_reg;
    end

    // ----------------------------------------
    // Link domain: output shifter
    // ----------------------------------------
    logic miso_next;
    logic moe_next;
    logic [7:0] obyte;

    // Byte and bit to present at the coming falling edge
    always_comb
    begin
        obyte = 8'h00;
        moe_next = 1'b0;
        unique case (osel_reg)
            fepi_pkg::FEPI_OUT_SIG:
            begin
                obyte = SIGNATURE_ID; // RULE_11
                moe_next = (bcnt_reg >= `FEPI_BITS_ID);
            end
            fepi_pkg::FEPI_OUT_MP:
            begin
                obyte = (bcnt_reg[3] ^ alsb_reg) ? PART_ID : MAKER_ID; // RULE_14
                moe_next = (bcnt_reg >= `FEPI_BITS_ID);
            end
            fepi_pkg::FEPI_OUT_ID:
            begin
                moe_next = (bcnt_reg >= `FEPI_BITS_OP);
                unique case (bcnt_reg[6:3])
                    4'h1: obyte = MAKER_ID; // RULE_15
                    4'h2: obyte = MEM_TYPE_ID;
                    4'h3: obyte = CAPACITY_ID;
                    default: obyte = 8'h00;
                endcase
            end
            fepi_pkg::FEPI_OUT_NONE: obyte = 8'h00;
        endcase
        miso_next = moe_next & obyte[~bcnt_reg[2:0]];
    end

    // Falling edge launch; deselect drops the driver at once
    always_ff @(negedge spi_clk_i or posedge spi_cs_n_i)
    begin
        if (spi_cs_n_i)
        begin
            spi_miso_o <= 1'b0;
            spi_miso_oe_o <= 1'b0; // RULE_15
        end
        else
        begin
            spi_miso_o <= miso_next;
            spi_miso_oe_o <= moe_next;
        end
    end

    // ----------------------------------------
    // System domain: frame end detect
    // ----------------------------------------
    logic cs1_reg;
    logic cs2_reg;
    logic cs3_reg;
    logic frame_end;

    // Two-flop chip select sync plus edge history
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            cs1_reg <= 1'b1;
            cs2_reg <= 1'b1;
            cs3_reg <= 1'b1;
        end
        else
        begin
            cs1_reg <= spi_cs_n_i;
            cs2_reg <= cs1_reg;
            cs3_reg <= cs2_reg;
        end
    end

    assign frame_end = cs2_reg & ~cs3_reg;

    // ----------------------------------------
    // System domain: control
    // ----------------------------------------
    localparam logic [31:0] ERASE_LOAD = 32'(ERASE_CYCLES - 1);
    localparam logic [31:0] SLEEP_LOAD = 32'(`FEPI_SLEEP_ENTRY_CYC - 1);
    localparam logic [31:0] WAKE_S_LOAD = 32'(`FEPI_WAKE_SHORT_CYC - 1);
    localparam logic [31:0] WAKE_L_LOAD = 32'(`FEPI_WAKE_WITH_ID_CYC - 1);

    fepi_pkg::fepi_state_type state_reg, state_next;
    logic [31:0] tmr_reg, tmr_next;
    logic wel_next, pump_next, cont_next, busy_next, dorm_next;
    logic ex8, ex32, has_op, busy_now, prot_ok;
    logic [3:0] prot;

    assign ex8 = (sum_cnt_reg == `FEPI_BITS_OP); // RULE_03
    assign ex32 = (sum_cnt_reg == `FEPI_BITS_ID);
    assign has_op = (sum_cnt_reg >= `FEPI_BITS_OP);
    assign busy_now = (state_reg == fepi_pkg::FEPI_ERASE) | ext_busy_i;
    assign prot = {protect_sel_2_i, protect_sel_1_i, protect_sel_0_i, protect_complement_i};
    assign prot_ok = (&prot) | ~(|prot); // RULE_05

    // Next state, timer and flags
    always_comb
    begin
        state_next = state_reg;
        tmr_next = (tmr_reg != 32'h0) ? tmr_reg - 32'h1 : 32'h0;
        wel_next = write_latch_flag_o;
        pump_next = pump_prearm_mode_o;
        cont_next = cont_read_active_o;
        if (write_latch_clr_i)
            wel_next = 1'b0;
        unique case (state_reg)
            fepi_pkg::FEPI_IDLE: state_next = fepi_pkg::FEPI_IDLE; // RULE_08
            fepi_pkg::FEPI_ERASE:
                if (tmr_reg == 32'h0)
                    state_next = fepi_pkg::FEPI_IDLE; // RULE_04
            fepi_pkg::FEPI_SLEEP_WAIT:
                if (tmr_reg == 32'h0)
                    state_next = fepi_pkg::FEPI_SLEEP; // RULE_06
            fepi_pkg::FEPI_SLEEP: state_next = fepi_pkg::FEPI_SLEEP;
            fepi_pkg::FEPI_WAKE:
                if (tmr_reg == 32'h0)
                    state_next = fepi_pkg::FEPI_IDLE; // RULE_10 RULE_12
        endcase
        // Sleeping: only the wake opcode counts
        if (frame_end && has_op && dorm_reg)
        begin
            if (sum_op_reg == `FEPI_OP_WAKE_SIG) // RULE_07
            begin
                state_next = fepi_pkg::FEPI_WAKE;
                tmr_next = (sum_cnt_reg >= `FEPI_BITS_ID) ? WAKE_L_LOAD : WAKE_S_LOAD; // RULE_12
            end
        end
        // Awake: decode, unless a wake delay is still running
        else if (frame_end && has_op && state_reg != fepi_pkg::FEPI_WAKE) // RULE_10
        begin
            if (cont_read_active_o)
            begin
                if (sum_op_reg == `FEPI_OP_CONT_CLEAR) // RULE_21
                    cont_next = 1'b0;
            end
            else
            begin
                unique case (sum_op_reg)
                    `FEPI_OP_ERASE_A, `FEPI_OP_ERASE_B: // RULE_01
                        if (ex8 && write_latch_flag_o && !busy_now && prot_ok) // RULE_02 RULE_05
                        begin
                            state_next = fepi_pkg::FEPI_ERASE; // RULE_04
                            tmr_next = ERASE_LOAD;
                            wel_next = 1'b0; // RULE_04
                        end
                    `FEPI_OP_WRITE_LATCH_SET:
                        if (ex8)
                        begin
                            wel_next = 1'b1; // RULE_02
                            pump_next = 1'b0; // RULE_19
                        end
                    `FEPI_OP_SLEEP_ENTRY:
                        if (ex8 && !busy_now) // RULE_09
                        begin
                            state_next = fepi_pkg::FEPI_SLEEP_WAIT; // RULE_06
                            tmr_next = SLEEP_LOAD;
                            pump_next = 1'b0; // RULE_19
                        end
                    `FEPI_OP_WAKE_SIG:
                        if (!busy_now) // RULE_13
                            pump_next = 1'b0; // RULE_19
                    `FEPI_OP_PUMP_PREARM:
                        if (ex32 && !busy_now)
                            pump_next = 1'b1; // RULE_18
                    default: pump_next = pump_prearm_mode_o;
                endcase
            end
        end
        // Mode bits from the read engine; a set beats a clear
        if (cont_read_bits_valid_i)
            cont_next = (cont_read_mode_bits_i[7:4] == `FEPI_CONT_TAG); // RULE_20
        busy_next = (state_next == fepi_pkg::FEPI_ERASE) | ext_busy_i; // RULE_04
        dorm_next = (state_next == fepi_pkg::FEPI_SLEEP_WAIT)
            | (state_next == fepi_pkg::FEPI_SLEEP);
    end

    // Control registers; power-up lands in standby
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= fepi_pkg::FEPI_IDLE; // RULE_08
            tmr_reg <= 32'h0;
            write_latch_flag_o <= 1'b0;
            pump_prearm_mode_o <= 1'b0;
            cont_read_active_o <= 1'b0;
            busy_flag_o <= 1'b0;
            dorm_reg <= 1'b0;
            sleep_o <= 1'b0;
            cmd_ready_o <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            write_latch_flag_o <= wel_next;
            pump_prearm_mode_o <= pump_next;
            cont_read_active_o <= cont_next;
            busy_flag_o <= busy_next;
            dorm_reg <= dorm_next;
            sleep_o <= (state_next == fepi_pkg::FEPI_SLEEP);
            cmd_ready_o <= (state_next != fepi_pkg::FEPI_WAKE);
        end
    end

endmodule // fepi_flash_cmds

`default_nettype wire

/* File: testbench/fepi_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fepi_defines.svh"

// ----------------------------------------
// Port checks, system clock domain
// ----------------------------------------
module fepi_checker #(
    parameter int ERASE_CYCLES = `FEPI_ARRAY_ERASE_CYC
) (
    input wire logic sys_clk_i, // System clock
    input wire logic nrst_i, // Sync reset, low
    input wire logic spi_cs_n_i, // Chip select, low
    input wire logic ext_busy_i, // Other cycle running
    input wire logic protect_sel_2_i, // Block protect 2
    input wire logic protect_sel_1_i, // Block protect 1
    input wire logic protect_sel_0_i, // Block protect 0
    input wire logic protect_complement_i, // Protect complement
    input wire logic [7:0] cont_read_mode_bits_i, // Mode bits
    input wire logic cont_read_bits_valid_i, // Mode bits strobe
    input wire logic spi_miso_oe_o, // Data out enable
    input wire logic busy_flag_o, // Cycle in progress
    input wire logic write_latch_flag_o, // Write latch
    input wire logic sleep_o, // Sleep mode
    input wire logic pump_prearm_mode_o, // Pump armed
    input wire logic cont_read_active_o, // Continuous read
    input wire logic cmd_ready_o // Commands accepted
);
    logic [7:0] low_cnt;
    logic [31:0] hi_cnt;
    logic ext_seen;
    logic [3:0] prot;

    assign prot = {protect_sel_2_i, protect_sel_1_i, protect_sel_0_i, protect_complement_i};

    // Run lengths; outside busy is noted so shared cycles are not timed
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            low_cnt <= 8'h00;
            hi_cnt <= 32'h0;
            ext_seen <= 1'b0;
        end
        else
        begin
            low_cnt <= (cmd_ready_o || sleep_o) ? 8'h00 : low_cnt + 8'h01;
            hi_cnt <= busy_flag_o ? hi_cnt + 32'h1 : 32'h0;
            ext_seen <= busy_flag_o ? (ext_seen | ext_busy_i) : ext_busy_i;
        end
    end

    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_reset_standby:
        assert property (disable iff (1'b0) !nrst_i |=> !sleep_o && !busy_flag_o && cmd_ready_o)
        else $error("not in standby after reset");
    a_erase_needs_latch:
        assert property ($rose(busy_flag_o) && !$past(ext_busy_i) |-> $past(write_latch_flag_o))
        else $error("erase started without latch");
    a_erase_clears_latch:
        assert property ($rose(busy_flag_o) && !$past(ext_busy_i) |-> !write_latch_flag_o)
        else $error("latch kept during erase");
    a_erase_protect_ok:
        assert property ($rose(busy_flag_o) && !$past(ext_busy_i) |-> $past(prot) inside {4'h0, 4'hf})
        else $error("erase started with mixed protection");
    a_erase_duration:
        assert property ($fell(busy_flag_o) && !ext_seen |-> hi_cnt == ERASE_CYCLES)
        else $error("erase length wrong");
    a_sleep_not_busy:
        assert property (busy_flag_o && !sleep_o |=> !sleep_o)
        else $error("sleep entered while busy");
    a_sleep_locks_flags:
        assert property (sleep_o |=> !$rose(write_latch_flag_o) && !$rose(pump_prearm_mode_o))
        else $error("command acted during sleep");
    a_wake_delay_len:
        assert property ($rose(cmd_ready_o) |->
            low_cnt == `FEPI_WAKE_SHORT_CYC || low_cnt == `FEPI_WAKE_WITH_ID_CYC)
        else $error("wake delay length wrong");
    a_busy_keeps_ready:
        assert property (busy_flag_o && cmd_ready_o |=> cmd_ready_o)
        else $error("wake acted while busy");
    a_oe_off_deselect:
        assert property (spi_cs_n_i |-> !spi_miso_oe_o)
        else $error("output enabled while deselected");
    a_mode_bits_track:
        assert property (cont_read_bits_valid_i |=>
            cont_read_active_o == ($past(cont_read_mode_bits_i[7:4]) == `FEPI_CONT_TAG))
        else $error("continuous read state wrong");
endmodule // fepi_checker

bind fepi_flash_cmds fepi_checker #(.ERASE_CYCLES(ERASE_CYCLES)) u_checker (
    .sys_clk_i, .nrst_i, .spi_cs_n_i, .ext_busy_i, .protect_sel_2_i, .protect_sel_1_i,
    .protect_sel_0_i, .protect_complement_i, .cont_read_mode_bits_i, .cont_read_bits_valid_i,
    .spi_miso_oe_o, .busy_flag_o, .write_latch_flag_o, .sleep_o, .pump_prearm_mode_o,
    .cont_read_active_o, .cmd_ready_o
);
`default_nettype wire

/* File: testbench/fepi_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Host controller, clock only within frames
// ----------------------------------------
module fepi_host_model (
    output logic spi_clk_o, // Serial clock
    output logic spi_cs_n_o, // Chip select, low
    output logic spi_mosi_o, // Data to device
    input wire logic spi_miso_i, // Data from device
    input wire logic spi_miso_oe_i // Device drives data
);
    // Idle: deselected, clock parked low
    initial
    begin
        spi_clk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end

    // One frame of n bits, 15 ns period; reply bits taken at rising edges
    task automatic xfer(input logic [63:0] d, input int n, output logic [63:0] q,
        output logic oe_seen);
        q = 64'h0;
        oe_seen = 1'b0;
        #3;
        spi_cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            spi_mosi_o = d[i];
            #7;
            spi_clk_o = 1'b1;
            q = {q[62:0], spi_miso_i};
            oe_seen = oe_seen | spi_miso_oe_i;
            #8;
            spi_clk_o = 1'b0;
        end
        #4;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o; // Released line must not keep its value
    endtask
endmodule // fepi_host_model
`default_nettype wire

/* File: testbench/fepi_flash_cmds_bench.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Command sequences and expected flags
// ----------------------------------------
module fepi_flash_cmds_bench;
    localparam logic [7:0] MK = 8'h11; // Arbitrary value
    localparam logic [7:0] PT = 8'h22; // Arbitrary value
    localparam logic [7:0] TY = 8'h33; // Arbitrary value
    localparam logic [7:0] CP = 8'h44; // Arbitrary value
    localparam logic [7:0] SG = 8'h55; // Arbitrary value
    logic sys_clk_i, nrst_i, ext_busy, latch_clr, mode_valid, oe_seen;
    logic [3:0] prot;
    logic [7:0] mode_bits;
    logic [63:0] got;
    wire spi_clk, spi_cs_n, spi_mosi, miso, oe, busy, latch, sleep, pump, cont, ready;
    int mismatches, n_checks, cycles;
    logic [7:0] erase_op [2] = '{8'h60, 8'hc7};
    logic [7:0] rel_op [3] = '{8'h06, 8'hab, 8'hb9};

    fepi_flash_cmds #(.ERASE_CYCLES(50), .MAKER_ID(MK), .PART_ID(PT), .MEM_TYPE_ID(TY),
        .CAPACITY_ID(CP), .SIGNATURE_ID(SG)) u_dut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .spi_clk_i(spi_clk), .spi_cs_n_i(spi_cs_n),
        .spi_mosi_i(spi_mosi), .ext_busy_i(ext_busy), .write_latch_clr_i(latch_clr),
        .protect_sel_2_i(prot[3]), .protect_sel_1_i(prot[2]), .protect_sel_0_i(prot[1]),
        .protect_complement_i(prot[0]), .cont_read_mode_bits_i(mode_bits),
        .cont_read_bits_valid_i(mode_valid), .spi_miso_o(miso), .spi_miso_oe_o(oe),
        .busy_flag_o(busy), .write_latch_flag_o(latch), .sleep_o(sleep),
        .pump_prearm_mode_o(pump), .cont_read_active_o(cont), .cmd_ready_o(ready));

    fepi_host_model u_host (.spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n), .spi_mosi_o(spi_mosi),
        .spi_miso_i(miso), .spi_miso_oe_i(oe));

    // System clock, 100 ns
    initial
    begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    // Hang guard, far beyond the expected run
    always @(posedge sys_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Settle away from the edge so registered flags have landed
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // Frame, then a gap long enough for the command to act
    task automatic frame(input logic [63:0] d, input int n);
        u_host.xfer(d, n, got, oe_seen);
        tick(6);
    endtask

    task automatic wait_ready();
        for (int k = 0; k < 100 && ready !== 1'b1; k++)
            @(posedge sys_clk_i);
        tick(1);
        check("ready", ready, 1'b1);
    endtask

    initial
    begin
        {nrst_i, ext_busy, latch_clr, mode_valid, prot, mode_bits} = '0;
        repeat (4) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        tick(4);
        check("standby", {busy, latch, sleep, pump, cont, ready}, 6'h01);
        frame(32'h9f000000, 32);
        check("identity", got[23:0], {MK, TY, CP});
        check("id oe", oe_seen, 1'b1);
        frame(48'h900000000000, 48);
        check("maker part", got[15:0], {MK, PT});
        frame(48'h900000010000, 48);
        check("part maker", got[15:0], {PT, MK});
        frame(48'hab0000000000, 48);
        check("signature", got[15:0], {SG, SG});
        wait_ready();
        frame(8'h60, 8);
        check("no latch", busy, 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge sys_clk_i);
            prot <= 4'h2;
            frame(8'h06, 8);
            check("latch", latch, 1'b1);
            frame({erase_op[k], 1'b0}, 9);
            check("long frame", busy, 1'b0);
            frame(erase_op[k], 8);
            check("mixed prot", busy, 1'b0);
            @(posedge sys_clk_i);
            prot <= k ? 4'hf : 4'h0;
            frame(8'h06, 8);
            frame(erase_op[k], 8);
            check("erase", {busy, latch}, 2'b10);
            tick(40);
            check("erasing", busy, 1'b1);
            tick(12);
            check("erased", busy, 1'b0);
        end
        frame(8'h06, 8);
        @(posedge sys_clk_i);
        latch_clr <= 1'b1;
        @(posedge sys_clk_i);
        latch_clr <= 1'b0;
        frame(8'h60, 8);
        check("cleared", {busy, latch}, 2'b00);
        @(posedge sys_clk_i);
        ext_busy <= 1'b1;
        frame(8'hb9, 8);
        tick(32);
        check("sleep busy", sleep, 1'b0);
        frame(48'hab0000000000, 48);
        check("wake busy", {ready, oe_seen}, 2'b10);
        frame(32'h9f000000, 32);
        check("id busy", oe_seen, 1'b0);
        @(posedge sys_clk_i);
        ext_busy <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            frame(32'ha3000000, 32);
            check("pump", pump, 1'b1);
            frame(rel_op[k], 8);
            check("pump off", pump, 1'b0);
            if (k < 2)
                wait_ready();
        end
        check("sleep delay", sleep, 1'b0);
        tick(30);
        check("sleep", sleep, 1'b1);
        frame(32'ha3000000, 32);
        check("sleep pump", pump, 1'b0);
        frame(8'hab, 8);
        check("wake", {sleep, ready}, 2'b00);
        frame(32'ha3000000, 32);
        check("wake refuse", pump, 1'b0);
        wait_ready();
        frame(8'hb9, 8);
        tick(30);
        check("sleep again", sleep, 1'b1);
        frame(48'hab0000000000, 48);
        check("wake sig", {sleep, got[15:0]}, {1'b0, SG, SG});
        wait_ready();
        @(posedge sys_clk_i);
        mode_bits <= 8'ha5;
        mode_valid <= 1'b1;
        @(posedge sys_clk_i);
        mode_valid <= 1'b0;
        tick(1);
        check("cont", cont, 1'b1);
        frame(32'ha3000000, 32);
        check("cont pump", pump, 1'b0);
        frame(8'hff, 8);
        check("cont clr", cont, 1'b0);
        test_done();
    end
endmodule // fepi_flash_cmds_bench
`default_nettype wire
